// File: design/rmcfg_regs.sv
// configuration register slice: spares, section checksums,
// test DAC code select and the two general-purpose pins
// assumes a single-cycle strobe register port on clock_in
module rmcfg_regs
    import rmcfg_pkg::*;
#(
    parameter int MCLK_DIV = 12 // system cycles per main-clock period
)
(
    input  wire logic              clock_in,      // system clock
    input  wire logic              rst_in,        // sync reset, high
    input  wire logic [ADDR_W-1:0] addr_in,       // register index
    input  wire logic [DATA_W-1:0] wdata_in,      // write data
    input  wire logic              wr_in,         // write strobe
    input  wire logic              rd_in,         // read strobe
    output logic      [DATA_W-1:0] rdata_out,     // read data
    output logic                   rvalid_out,    // read data valid
    output logic      [15:0]       section_two_checksum_value_out, // stored checksum
    output logic                   section_three_checksum_enable_out, // protection on
    output logic                   section_three_write_out, // protected write seen
    output logic      [2:0]        test_dac_level_code_out, // level code
    output logic signed [6:0]      test_dac_multiplier_out, // fortieths of ref b
    input  wire logic [1:0]        pin_in,        // pin levels from pads
    output logic      [1:0]        pin_out,       // pin drive levels
    output logic      [1:0]        pin_oe_out,    // pin drive enables
    output logic      [1:0]        pin_level_out  // decoded input levels
);

    // write decode
    logic wr_spare_a;
    logic wr_spare_b;
    logic wr_sec2;
    logic wr_sec3;
    logic wr_pin;
    logic in_sec3;

    // storage
    logic [7:0]  spare_a_hi;
    logic [15:0] spare_b;
    logic [15:0] section_two_checksum_value;
    logic        section_three_checksum_enable;
    logic [2:0]  test_dac_level_code;
    logic [2:0]  pin_spare_hi;
    logic [1:0]  pin_spare_lo;
    logic [1:0]  pin_format;
    logic [1:0]  pin_direction;
    logic [1:0]  pin_one_decode_timebase;
    logic [1:0]  pin_zero_decode_timebase;
    logic [1:0]  pin_output_level;

    // readback images
    logic [15:0] spare_a_img;
    logic [15:0] sec3_img;
    logic [15:0] pin_cfg_img;
    logic [15:0] pin_stat_img;
    logic [15:0] next_rdata;

    // main-clock divider
    logic [$clog2(MCLK_DIV+1)-1:0] div_cnt;
    logic                          mclk_tick;
    logic [1:0]                    decoded;
    logic [1:0]                    tb_sel [NUM_PINS];

    // one write strobe per stored register; unmapped indices fall through
    always_comb begin
        wr_spare_a = 1'b0;
        wr_spare_b = 1'b0;
        wr_sec2    = 1'b0;
        wr_sec3    = 1'b0;
        wr_pin     = 1'b0;
        if (wr_in) begin
            if (addr_in == SPARE_A_ADDR) begin
                wr_spare_a = 1'b1;
            end else if (addr_in == SPARE_B_ADDR) begin
                wr_spare_b = 1'b1;
            end else if (addr_in == SEC2_CRC_ADDR) begin
                wr_sec2 = 1'b1;
            end else if (addr_in == SEC3_TDAC_ADDR) begin
                wr_sec3 = 1'b1;
            end else if (addr_in == PIN_CFG_ADDR) begin
                wr_pin = 1'b1;
            end
        end
    end

    // whole protected span counts, mapped here or not
    assign in_sec3 = (addr_in >= SEC3_LO_ADDR) && (addr_in <= SEC3_HI_ADDR);

    // spare words: only the checksum engine ever cares
    // low byte of the first spare is not stored, so it always reads zero
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            spare_a_hi <= SPARE_A_RST[15:SPARE_A_LSB];
        end else if (wr_spare_a) begin
            spare_a_hi <= wdata_in[15:SPARE_A_LSB];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            spare_b <= SPARE_B_RST;
        end else if (wr_spare_b) begin
            spare_b <= wdata_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            section_two_checksum_value <= SEC2_CRC_RST;
        end else if (wr_sec2) begin
            section_two_checksum_value <= wdata_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            section_three_checksum_enable <= SEC3_TDAC_RST[SEC3_EN_BIT];
            test_dac_level_code           <= SEC3_TDAC_RST[TDAC_LSB +: TDAC_W];
        end else if (wr_sec3) begin
            section_three_checksum_enable <= wdata_in[SEC3_EN_BIT];
            test_dac_level_code           <= wdata_in[TDAC_LSB +: TDAC_W];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_spare_hi <= PIN_CFG_RST[PIN_SPARE_HI_LSB +: 3];
            pin_spare_lo <= PIN_CFG_RST[PIN_SPARE_LO_LSB +: 2];
        end else if (wr_pin) begin
            pin_spare_hi <= wdata_in[PIN_SPARE_HI_LSB +: 3];
            pin_spare_lo <= wdata_in[PIN_SPARE_LO_LSB +: 2];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_format    <= PIN_CFG_RST[PIN_FMT_LSB +: 2];
            pin_direction <= PIN_CFG_RST[PIN_DIR_LSB +: 2];
        end else if (wr_pin) begin
            pin_format    <= wdata_in[PIN_FMT_LSB +: 2];
            pin_direction <= wdata_in[PIN_DIR_LSB +: 2];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_one_decode_timebase  <= PIN_CFG_RST[PIN_TB_LSB+2 +: 2];
            pin_zero_decode_timebase <= PIN_CFG_RST[PIN_TB_LSB +: 2];
        end else if (wr_pin) begin
            pin_one_decode_timebase  <= wdata_in[PIN_TB_LSB+2 +: 2];
            pin_zero_decode_timebase <= wdata_in[PIN_TB_LSB +: 2];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pin_output_level <= PIN_CFG_RST[PIN_DAT_LSB +: 2];
        end else if (wr_pin) begin
            pin_output_level <= wdata_in[PIN_DAT_LSB +: 2];
        end
    end

    // readback images; reserved bits are constants, never stored
    always_comb begin
        spare_a_img = {spare_a_hi, 8'h00};
        sec3_img = {section_three_checksum_enable, 12'h000, test_dac_level_code};
        pin_cfg_img = {1'b1,
                       pin_spare_hi,
                       pin_format,
                       pin_direction,
                       pin_one_decode_timebase,
                       pin_zero_decode_timebase,
                       pin_spare_lo,
                       pin_output_level};
        // decoded levels before the output-pin mask
        pin_stat_img = {14'h0000, decoded};
    end

    // unmapped indices read as zero
    always_comb begin
        if (addr_in == SPARE_A_ADDR) begin
            next_rdata = spare_a_img;
        end else if (addr_in == SPARE_B_ADDR) begin
            next_rdata = spare_b;
        end else if (addr_in == SEC2_CRC_ADDR) begin
            next_rdata = section_two_checksum_value;
        end else if (addr_in == SEC3_TDAC_ADDR) begin
            next_rdata = sec3_img;
        end else if (addr_in == PIN_CFG_ADDR) begin
            next_rdata = pin_cfg_img;
        end else if (addr_in == PIN_STAT_ADDR) begin
            next_rdata = pin_stat_img;
        end else begin
            next_rdata = 16'h0000;
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd_in;
        end
    end

    // zero outside the answer cycle so a stale word is never taken for data
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= rd_in ? next_rdata : 16'h0000;
        end
    end

    // checksum engine hooks
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            section_two_checksum_value_out <= SEC2_CRC_RST;
        end else begin
            section_two_checksum_value_out <= section_two_checksum_value;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            section_three_checksum_enable_out <= 1'b0;
        end else begin
            section_three_checksum_enable_out <= section_three_checksum_enable;
        end
    end

    // the engine must refresh its reference after such a write
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            section_three_write_out <= 1'b0;
        end else begin
            section_three_write_out <= wr_in && in_sec3 && section_three_checksum_enable;
        end
    end

    // test DAC code and the level it stands for
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            test_dac_level_code_out <= 3'h0;
        end else begin
            test_dac_level_code_out <= test_dac_level_code;
        end
    end

    // a table keeps the negative codes out of any arithmetic
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            test_dac_multiplier_out <= TDAC_MUL0;
        end else begin
            case (test_dac_level_code)
                3'h0:    test_dac_multiplier_out <= TDAC_MUL0;
                3'h1:    test_dac_multiplier_out <= TDAC_MUL1;
                3'h2:    test_dac_multiplier_out <= TDAC_MUL2;
                3'h3:    test_dac_multiplier_out <= TDAC_MUL3;
                3'h4:    test_dac_multiplier_out <= TDAC_MUL4;
                3'h5:    test_dac_multiplier_out <= TDAC_MUL5;
                3'h6:    test_dac_multiplier_out <= TDAC_MUL6;
                default: test_dac_multiplier_out <= TDAC_MUL7;
            endcase
        end
    end

    // main-clock enable; the decoder time base counts these ticks
    // a divisor of one ticks every cycle, which keeps decode windows short
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            div_cnt <= '0;
        end else if (div_cnt == ($clog2(MCLK_DIV+1))'(MCLK_DIV - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mclk_tick <= 1'b0;
        end else begin
            mclk_tick <= (div_cnt == ($clog2(MCLK_DIV+1))'(MCLK_DIV - 1));
        end
    end

    assign tb_sel[0] = pin_zero_decode_timebase;
    assign tb_sel[1] = pin_one_decode_timebase;

    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
            rmcfg_pin_channel u_chan (
                .clock_in    (clock_in),
                .rst_in      (rst_in),
                .tick_in     (mclk_tick),
                .pin_in      (pin_in[i]),
                .format_in   (pin_format[i]),
                .timebase_in (tb_sel[i]),
                .level_out   (decoded[i])
            );

            // static drive only; format never reaches the driver
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    pin_oe_out[i] <= 1'b0;
                end else begin
                    pin_oe_out[i] <= pin_direction[i];
                end
            end

            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    pin_out[i] <= 1'b0;
                end else begin
                    pin_out[i] <= pin_direction[i] & pin_output_level[i];
                end
            end

            // an output pin reports nothing decoded
            always_ff @(posedge clock_in) begin
                if (rst_in) begin
                    pin_level_out[i] <= 1'b0;
                end else begin
                    pin_level_out[i] <= ~pin_direction[i] & decoded[i];
                end
            end
        end
    endgenerate

endmodule // rmcfg_regs

// File: design/rmcfg_pkg.sv
// constants for the configuration register slice
// assumes an 8-bit register index and 16-bit register data
package rmcfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register indices as printed
    localparam logic [7:0] SPARE_A_ADDR  = 8'hA2;
    localparam logic [7:0] SPARE_B_ADDR  = 8'hA3;
    localparam logic [7:0] SEC2_CRC_ADDR = 8'hBE;
    localparam logic [7:0] SEC3_TDAC_ADDR = 8'hC0;
    localparam logic [7:0] PIN_CFG_ADDR  = 8'hC1;
    localparam logic [7:0] PIN_STAT_ADDR = 8'hF0;

    // section-3 protected address range
    localparam logic [7:0] SEC3_LO_ADDR = 8'hC0;
    localparam logic [7:0] SEC3_HI_ADDR = 8'hE3;

    // reset values
    localparam logic [15:0] SPARE_A_RST  = 16'h0000;
    localparam logic [15:0] SPARE_B_RST  = 16'h0000;
    localparam logic [15:0] SEC2_CRC_RST = 16'h0000;
    localparam logic [15:0] SEC3_TDAC_RST = 16'h0000;
    localparam logic [15:0] PIN_CFG_RST  = 16'h8000;

    // field positions
    localparam int SPARE_A_LSB    = 8;
    localparam int SEC3_EN_BIT    = 15;
    localparam int TDAC_LSB       = 0;
    localparam int TDAC_W         = 3;
    localparam int PIN_FIXED_BIT  = 15;
    localparam int PIN_SPARE_HI_LSB = 12;
    localparam int PIN_FMT_LSB    = 10;
    localparam int PIN_DIR_LSB    = 8;
    localparam int PIN_TB_LSB     = 4;
    localparam int PIN_SPARE_LO_LSB = 2;
    localparam int PIN_DAT_LSB    = 0;
    localparam int NUM_PINS       = 2;

    // decode time base in main-clock periods
    localparam logic [10:0] TB_CODE0 = 11'h010;
    localparam logic [10:0] TB_CODE1 = 11'h040;
    localparam logic [10:0] TB_CODE2 = 11'h100;
    localparam logic [10:0] TB_CODE3 = 11'h400;

    // test DAC level in fortieths of reference b
    localparam logic signed [6:0] TDAC_MUL0 = 7'sh01;
    localparam logic signed [6:0] TDAC_MUL1 = 7'sh02;
    localparam logic signed [6:0] TDAC_MUL2 = 7'sh04;
    localparam logic signed [6:0] TDAC_MUL3 = 7'sh09;
    localparam logic signed [6:0] TDAC_MUL4 = 7'sh12;
    localparam logic signed [6:0] TDAC_MUL5 = 7'sh24;
    localparam logic signed [6:0] TDAC_MUL6 = -7'sh04;
    localparam logic signed [6:0] TDAC_MUL7 = -7'sh09;

endpackage

// File: design/rmcfg_pin_channel.sv
// one pin input path: synchroniser, static level and pwm decoder
// assumes tick_in is a one-cycle main-clock enable
module rmcfg_pin_channel
    import rmcfg_pkg::*;
(
    input  wire logic       clock_in,    // system clock
    input  wire logic       rst_in,      // sync reset, high
    input  wire logic       tick_in,     // main-clock enable
    input  wire logic       pin_in,      // raw pin level
    input  wire logic       format_in,   // 1 = pwm decode
    input  wire logic [1:0] timebase_in, // decode time base code
    output logic            level_out    // decoded level
);

    logic        sync_a;
    logic        sync_b;
    logic [10:0] span;
    logic [1:0]  tb_seen;
    logic [10:0] win_cnt;
    logic [10:0] high_cnt;
    logic [10:0] next_high;
    logic        pwm_level;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    always_comb begin
        case (timebase_in)
            2'b00:   span = TB_CODE0;
            2'b01:   span = TB_CODE1;
            2'b10:   span = TB_CODE2;
            default: span = TB_CODE3;
        endcase
    end

    assign next_high = high_cnt + {10'h000, sync_b};

    // majority of high samples over one window decides the level
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            win_cnt   <= 11'h000;
            high_cnt  <= 11'h000;
            tb_seen   <= 2'b00;
            pwm_level <= 1'b0;
        end else if (tb_seen != timebase_in) begin
            // restart so a window never mixes two time bases
            tb_seen  <= timebase_in;
            win_cnt  <= 11'h000;
            high_cnt <= 11'h000;
        end else if (tick_in) begin
            if (win_cnt == span - 11'h001) begin
                win_cnt   <= 11'h000;
                high_cnt  <= 11'h000;
                pwm_level <= {next_high, 1'b0} > {1'b0, span};
            end else begin
                win_cnt  <= win_cnt + 11'h001;
                high_cnt <= next_high;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            level_out <= 1'b0;
        end else begin
            level_out <= format_in ? pwm_level : sync_b;
        end
    end

endmodule // rmcfg_pin_channel

// File: tb/rmcfg_chk.sv
// checker for the configuration register slice
// assumes it sees only the ports of rmcfg_regs
module rmcfg_chk
    import rmcfg_pkg::*;
(
    input wire logic              clock_in,  // clk
    input wire logic              rst_in,    // rst
    input wire logic [ADDR_W-1:0] addr_in,   // index
    input wire logic [DATA_W-1:0] wdata_in,  // wdata
    input wire logic              wr_in,     // write
    input wire logic              rd_in,     // read
    input wire logic [DATA_W-1:0] rdata_out, // rdata
    input wire logic              rvalid_out, // valid
    input wire logic [15:0]       section_two_checksum_value_out, // crc
    input wire logic              section_three_checksum_enable_out, // en
    input wire logic [2:0]        test_dac_level_code_out, // code
    input wire logic signed [6:0] test_dac_multiplier_out, // mult
    input wire logic [1:0]        pin_out,   // drive
    input wire logic [1:0]        pin_oe_out // enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    localparam logic signed [6:0] MUL [8] = '{7'sh01, 7'sh02, 7'sh04, 7'sh09, 7'sh12, 7'sh24, -7'sh04, -7'sh09};
    logic wc1;
    logic wc0;
    assign wc1 = wr_in && addr_in == PIN_CFG_ADDR;
    assign wc0 = wr_in && addr_in == SEC3_TDAC_ADDR;

    property p_rvalid; rvalid_out == $past(rd_in); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid off");
    property p_a2_low; rd_in && addr_in == SPARE_A_ADDR |=> rdata_out[7:0] == 8'h00; endproperty
    a_a2_low: assert property (p_a2_low) else $error("spare low byte not zero");
    property p_dir; wc1 |-> ##2 pin_oe_out == $past(wdata_in[9:8], 2); endproperty
    a_dir: assert property (p_dir) else $error("enable not direction");
    property p_dat; wc1 |-> ##2 pin_out == ($past(wdata_in[9:8], 2) & $past(wdata_in[1:0], 2)); endproperty
    a_dat: assert property (p_dat) else $error("drive level wrong");
    // no toggling without a config write rules out any pwm drive
    property p_stat; $changed(pin_out) |-> $past(wr_in, 2) && $past(addr_in, 2) == PIN_CFG_ADDR; endproperty
    a_stat: assert property (p_stat) else $error("drive moved alone");
    property p_en; wc0 |-> ##2 section_three_checksum_enable_out == $past(wdata_in[15], 2); endproperty
    a_en: assert property (p_en) else $error("protect enable wrong");
    property p_code; wc0 |-> ##2 test_dac_level_code_out == $past(wdata_in[2:0], 2); endproperty
    a_code: assert property (p_code) else $error("level code wrong");
    property p_mul; test_dac_multiplier_out == MUL[test_dac_level_code_out]; endproperty
    a_mul: assert property (p_mul) else $error("multiplier wrong");
    property p_crc; wr_in && addr_in == SEC2_CRC_ADDR |-> ##2 section_two_checksum_value_out == $past(wdata_in, 2);
    endproperty
    a_crc: assert property (p_crc) else $error("checksum copy wrong");
endmodule // rmcfg_chk

bind rmcfg_regs rmcfg_chk u_chk (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .section_two_checksum_value_out(section_two_checksum_value_out),
    .section_three_checksum_enable_out(section_three_checksum_enable_out),
    .test_dac_level_code_out(test_dac_level_code_out), .test_dac_multiplier_out(test_dac_multiplier_out),
    .pin_out(pin_out), .pin_oe_out(pin_oe_out));

// File: tb/rmcfg_pin_model.sv
// far-side logic on the two pins: static level or 16-cycle pwm
// assumes pin_oe_out high means the device drives that pin
module rmcfg_pin_model (
    input  wire logic       clock_in,   // system clock
    input  wire logic [1:0] pin_out,    // device drive level
    input  wire logic [1:0] pin_oe_out, // device drive enable
    input  wire logic [1:0] level_in,   // static level shown
    input  wire logic [1:0] pwm_in,     // 1 = show pwm
    input  wire logic [4:0] duty_in,    // high cycles of 16, pin 1 inverted
    output logic      [1:0] pin_in      // resolved pin level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase = 4'h0;
    logic [1:0] far;
    always_ff @(posedge clock_in) phase <= phase + 4'h1;
    // period 16 divides every window, so the duty seen is phase independent
    assign far[0] = pwm_in[0] ? ({1'b0, phase} < duty_in) : level_in[0];
    assign far[1] = pwm_in[1] ? !({1'b0, phase} < duty_in) : level_in[1];
    assign pin_in = (pin_oe_out & pin_out) | (~pin_oe_out & far);
endmodule // rmcfg_pin_model

// File: tb/rmcfg_regs_tb_top.sv
// testbench for the configuration register slice
// assumes rmcfg_regs, the pin model and the bound checker
module rmcfg_regs_tb_top
    import rmcfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000, rdata_out, crc2;
    logic rvalid_out, en3, wr3;
    logic [2:0] code;
    logic signed [6:0] mult;
    logic [1:0] pin_in, pin_out, pin_oe_out, pin_level_out, level = 2'b00, pwm = 2'b00;
    logic [4:0] duty = 5'h00;
    int miscompares = 0, samples_checked = 0, i, c, t;
    localparam logic signed [6:0] MUL [8] = '{7'sh01, 7'sh02, 7'sh04, 7'sh09, 7'sh12, 7'sh24, -7'sh04, -7'sh09};
    localparam logic [23:0] RST [5] = '{24'hA20000, 24'hA30000, 24'hBE0000, 24'hC00000, 24'hC18000};
    localparam logic [39:0] ROWS [7] = '{40'hA2FFFFFF00, 40'hA3A5C3A5C3, 40'hBE12341234, 40'hC0FFFF8007,
        40'hC17FFFFFFF, 40'hC100008000, 40'hA4FFFF0000};

    rmcfg_regs #(.MCLK_DIV(1)) uut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .section_two_checksum_value_out(crc2), .section_three_checksum_enable_out(en3),
        .section_three_write_out(wr3), .test_dac_level_code_out(code), .test_dac_multiplier_out(mult),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pin_level_out(pin_level_out));
    rmcfg_pin_model u_pins (.clock_in(clock_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .level_in(level),
        .pwm_in(pwm), .duty_in(duty), .pin_in(pin_in));

    initial forever #5 clock_in = ~clock_in;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        check(16'(rvalid_out), 16'h0001);
        check(rdata_out, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        print_verdict;
    end

    initial begin
        repeat (6) @(posedge clock_in);
        rst_in <= 1'b0;
        for (i = 0; i < 5; i++) rd(RST[i][23:16], RST[i][15:0]);
        for (i = 0; i < 7; i++) begin
            wr(ROWS[i][39:32], ROWS[i][31:16]);
            rd(ROWS[i][39:32], ROWS[i][15:0]);
        end
        $display("register rows done");
        for (c = 0; c < 8; c++) begin
            wr(SEC3_TDAC_ADDR, {c[0], 12'h000, c[2:0]});
            cyc(1);
            check(16'(mult), 16'(MUL[c]));
            check(16'(en3), 16'(c[0]));
        end
        wr(8'hE3, 16'h0000);
        check(16'(wr3), 16'h0001);
        wr(8'hE4, 16'h0000);
        check(16'(wr3), 16'h0000);
        wr(SEC3_TDAC_ADDR, 16'h0000);
        wr(8'hC5, 16'h0000);
        check(16'(wr3), 16'h0000);
        $display("test dac and protection done");
        wr(PIN_CFG_ADDR, 16'h0000);
        @(posedge clock_in);
        level <= 2'b10;
        cyc(6);
        check(16'({pin_oe_out, pin_level_out}), 16'h0002);
        @(posedge clock_in);
        level <= 2'b01;
        cyc(2);
        check(16'(pin_level_out), 16'h0002);
        cyc(3);
        check(16'(pin_level_out), 16'h0001);
        rd(PIN_STAT_ADDR, 16'h0001);
        // format set on outputs must still give static drive
        wr(PIN_CFG_ADDR, 16'h0F01);
        cyc(1);
        check(16'({pin_oe_out, pin_out}), 16'h000D);
        cyc(40);
        check(16'({pin_out, pin_level_out}), 16'h0004);
        wr(PIN_CFG_ADDR, 16'h0003);
        cyc(1);
        check(16'({pin_oe_out, pin_out}), 16'h0000);
        $display("static pins done");
        for (c = 0; c < 4; c++) begin
            t = 16 << (2 * (c ^ 1));
            @(posedge clock_in);
            pwm <= 2'b11;
            duty <= 5'h04;
            wr(PIN_CFG_ADDR, 16'h0C00 + 16'((c ^ 1) * 16'h0050));
            cyc(2 * t + 10);
            check(16'(pin_level_out), 16'h0002);
            t = 16 << (2 * c);
            @(posedge clock_in);
            duty <= 5'h0C;
            wr(PIN_CFG_ADDR, 16'h0C00 + 16'(c * 16'h0050));
            cyc(t - 6);
            check(16'(pin_level_out), 16'h0002);
            cyc(16);
            check(16'(pin_level_out), 16'h0001);
        end
        $display("pwm time bases done");
        @(posedge clock_in);
        rst_in <= 1'b1;
        cyc(2);
        @(posedge clock_in);
        rst_in <= 1'b0;
        rd(PIN_CFG_ADDR, 16'h8000);
        rd(SEC2_CRC_ADDR, 16'h0000);
        check(16'({pin_oe_out, pin_out}), 16'h0000);
        $display("second reset done");
        print_verdict;
    end
endmodule // rmcfg_regs_tb_top
